/* common/supply_monitor_map.svh */
`ifndef SUPPLY_MONITOR_MAP_SVH
`define SUPPLY_MONITOR_MAP_SVH

// Register offsets (byte addresses)
`define SMON_ADDR_W 4
`define SMON_OFF_MODE 4'h0
`define SMON_OFF_TRIP 4'h1
`define SMON_OFF_MARGIN 4'h8
`define SMON_OFF_IRQCTL 4'h9
`define SMON_OFF_FLAGS 4'hA
`define SMON_OFF_STATE 4'hB
`define SMON_OFF_GUARD 4'hC

// Field positions
`define SMON_SLEEP_LSB 0
`define SMON_ACTIVE_LSB 2
`define SMON_SAMPFREQ_BIT 4
`define SMON_IE_BIT 0
`define SMON_EDGE_LSB 1
`define SMON_FLAG_BIT 0
`define SMON_STATE_BIT 0

// Reset values
`define SMON_MARGIN_RST 8'h00
`define SMON_IRQCTL_RST 8'h00
`define SMON_FLAGS_RST 8'h00

// Unlock key and window
`define SMON_UNLOCK_KEY 8'hD8
`define SMON_UNLOCK_WINDOW 3'h4

// Sampled mode strobe: 1 kHz at 25 MHz clock
`define SMON_CLK_HZ 25000000
`define SMON_SAMPLE_HZ 1000
`define SMON_SAMPLE_CYCLES (`SMON_CLK_HZ / `SMON_SAMPLE_HZ)

`endif

/* common/supply_monitor_pkg.sv */
package supply_monitor_pkg;

    // Detector operating mode
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_CONT = 2'h1,
        MODE_SAMPLED = 2'h2,
        MODE_RSVD = 2'h3
    } det_mode_t;

    // Warning edge selection
    typedef enum logic [1:0] {
        EDGE_BELOW = 2'h0,
        EDGE_ABOVE = 2'h1,
        EDGE_CROSS = 2'h2,
        EDGE_RSVD = 2'h3
    } warn_edge_t;

    // Boot option word carried at reset
    typedef struct packed {
        logic [2:0] tripLevel;
        logic sampFreq;
        det_mode_t activeMode;
        det_mode_t sleepMode;
    } boot_opt_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : supply_monitor_pkg

/* dv/supply_monitor_props.sv */
`timescale 1ns/1ns
`default_nettype none
module supply_monitor_props
    import supply_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire supply_monitor_pkg::boot_opt_t bootOptWord,
    input wire logic bootLoad,
    input wire logic deepSleep,
    input wire logic belowWarnAsync,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic detEnable,
    input wire logic detSampled,
    input wire logic [2:0] tripLevelSel,
    input wire logic [1:0] warnMarginSel,
    input wire logic warnIrq
);
    logic ieR;
    logic [1:0] edgeR;
    // Decodes used by the properties
    wire logic ctlWr = regWr && regAddr == 4'h9;
    wire logic contOn = detEnable && !detSampled;
    wire logic [1:0] wMargin = regWdata[1:0];
    wire logic [1:0] modeSel = deepSleep ? regRdata[1:0] : regRdata[3:2];
    // Shadow of the enable and edge fields
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ieR <= 1'b0;
            edgeR <= 2'h0;
        end else if (ctlWr) begin
            ieR <= regWdata[0];
            edgeR <= regWdata[2:1];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Comparator quiet long enough that no set is in flight
    sequence quietIn;
        $stable(belowWarnAsync)[*6];
    endsequence
    sequence flagClr;
        regWr && regAddr == 4'hA && regWdata[0] && contOn;
    endsequence
    a_irq_masked: assert property (
        ctlWr && !regWdata[0] |=> !warnIrq) else $error("irq when masked");
    a_w1c_clear: assert property (
        quietIn ##0 flagClr |=> !warnIrq) else $error("flag not cleared");
    a_trip_read: assert property (
        regRd && regAddr == 4'h1 |=> regRdata == {5'h0, tripLevelSel})
        else $error("trip read");
    a_margin_write: assert property (
        regWr && regAddr == 4'h8 |=> warnMarginSel == $past(wMargin))
        else $error("margin write");
    a_mode_follow: assert property (
        regRd && regAddr == 4'h0 && !bootLoad |=> detEnable ==
        (modeSel != 2'h0) && detSampled == (modeSel == 2'h2))
        else $error("detector mode");
    a_hold_off: assert property (
        !detEnable && !regWr |=> $stable(warnIrq)) else $error("flag moved");
    a_raise_irq: assert property (
        $rose(belowWarnAsync) && ieR && !edgeR[0] && contOn |->
        ##[1:6] warnIrq) else $error("no irq on fall");
    a_flag_read: assert property (
        regRd && regAddr == 4'hA && ieR |=> regRdata == {7'h0,
        $past(warnIrq)}) else $error("flag read");
endmodule : supply_monitor_props
bind supply_monitor_ctrl_regs supply_monitor_props props (.clk, .arst_n,
    .bootOptWord, .bootLoad, .deepSleep, .belowWarnAsync, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .detEnable, .detSampled,
    .tripLevelSel, .warnMarginSel, .warnIrq);
`default_nettype wire

/* dv/supply_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module supply_partner
    import supply_monitor_pkg::*;
#(
    parameter logic [7:0] BOOT = 8'hF6
) (
    input wire logic belowLevel,
    output logic belowWarnAsync,
    output supply_monitor_pkg::boot_opt_t bootOptWord
);
    // Comparator settles 7 ns after the level moves, off the clock edge
    assign #7 belowWarnAsync = belowLevel;
    assign bootOptWord = BOOT;
endmodule : supply_partner
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import supply_monitor_pkg::*;
    logic clk, arst_n, deepSleep, level, regWr, regRd, warnIrq;
    logic detEnable, detSampled, belowWarnAsync, bootLoad;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [2:0] tripLevelSel;
    logic [1:0] warnMarginSel;
    boot_opt_t bootOptWord;
    int n_fail, total_checks;
    supply_partner #(.BOOT(8'hE6)) cmp (.belowLevel(level), .belowWarnAsync,
        .bootOptWord);
    supply_monitor_ctrl_regs dut (.clk, .arst_n, .bootOptWord,
        .bootLoad, .deepSleep, .belowWarnAsync, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .detEnable, .detSampled, .tripLevelSel,
        .warnMarginSel, .warnIrq);
    // Compare and count
    task automatic chk(input string w, input logic [7:0] e, a);
        total_checks++;
        if (a !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", w, e, a);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk("regRdata", e, regRdata);
        @(posedge clk);
    endtask : rd
    task automatic irq(input int n, input logic e);
        repeat (n) @(posedge clk);
        #1 chk("warnIrq", {7'h0, e}, {7'h0, warnIrq});
        @(posedge clk);
    endtask : irq
    // Detector enable and sampled outputs, then back on the clock edge
    task automatic mode(input logic [7:0] e);
        #1 chk("mode", e, {6'h0, detEnable, detSampled});
        @(posedge clk);
    endtask : mode
    task automatic close_out();
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // Boot loaded fields and reset values, then plain writes
    task automatic regs_basic();
        int m;
        rd(4'h0, 8'h06);
        rd(4'h1, 8'h07);
        chk("trip", 8'h07, {5'h0, tripLevelSel});
        rd(4'hA, 8'h00);
        rd(4'hB, 8'h00);
        rd(4'h5, 8'h00);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'h07);
        for (m = 0; m < 3; m++) begin
            wr(4'h8, 8'(m));
            rd(4'h8, 8'(m));
            chk("margin", 8'(m), {6'h0, warnMarginSel});
        end
    endtask : regs_basic
    // Every edge choice, masking and one-to-clear
    task automatic edges();
        int e;
        for (e = 0; e < 3; e++) begin
            wr(4'h9, {5'h0, e[1:0], 1'b1});
            level <= 1'b1;
            irq(8, e != 1);
            rd(4'hA, {7'h0, e != 1});
            rd(4'hB, 8'h01);
            wr(4'hA, 8'h00);
            irq(0, e != 1);
            wr(4'h9, {5'h0, e[1:0], 1'b0});
            irq(0, 1'b0);
            wr(4'hA, 8'h01);
            rd(4'hA, 8'h00);
            wr(4'h9, {5'h0, e[1:0], 1'b1});
            level <= 1'b0;
            irq(8, e != 0);
            rd(4'hB, 8'h00);
            wr(4'hA, 8'h01);
        end
    endtask : edges
    // Guarded sleep field, sleep switching and hold while off
    task automatic sleep_modes();
        deepSleep <= 1'b1;
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h06);
        mode(8'h03);
        wr(4'hC, 8'hD8);
        repeat (3) rd(4'h8, 8'h02);
        wr(4'h0, 8'h03);
        rd(4'h0, 8'h07);
        mode(8'h02);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h07);
        wr(4'hC, 8'hD8);
        wr(4'h0, 8'h00);
        level <= 1'b1;
        irq(8, 1'b0);
        mode(8'h00);
        level <= 1'b0;
        irq(8, 1'b0);
        deepSleep <= 1'b0;
        irq(8, 1'b0);
        mode(8'h02);
    endtask : sleep_modes
    // Boot reload restores sampled sleep mode; warning lands on a tick
    task automatic sampled_warn();
        int k;
        bootLoad <= 1'b1;
        deepSleep <= 1'b1;
        @(posedge clk);
        bootLoad <= 1'b0;
        @(posedge clk);
        rd(4'h0, 8'h06);
        mode(8'h03);
        level <= 1'b1;
        for (k = 0; k < 25100 && warnIrq !== 1'b1; k++) begin
            @(posedge clk);
        end
        irq(0, 1'b1);
        rd(4'hB, 8'h01);
        wr(4'hA, 8'h01);
        rd(4'hA, 8'h00);
        deepSleep <= 1'b0;
    endtask : sampled_warn
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Reset, scenarios, verdict
    initial begin
        n_fail = 0;
        total_checks = 0;
        arst_n = 1'b0;
        {regWr, regRd, deepSleep, level, bootLoad} = 5'h00;
        regAddr = 4'h0;
        regWdata = 8'h00;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        regs_basic();
        edges();
        sleep_modes();
        sampled_warn();
        close_out();
    end
endmodule : testbench
`default_nettype wire

/* hw/sample_strobe.sv */
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_map.svh"
module sample_strobe (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slowRate,
    output logic tick
);
    localparam logic [17:0] FAST_CNT = 18'(`SMON_SAMPLE_CYCLES - 1);
    localparam logic [17:0] SLOW_CNT = 18'((`SMON_SAMPLE_CYCLES * 8) - 1);
    logic [17:0] count_r;
    logic [17:0] limit;
    logic atEnd;

    assign limit = slowRate ? SLOW_CNT : FAST_CNT;
    assign atEnd = (count_r >= limit);

    // Free-running divider giving a one-cycle sample pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= 18'h00000;
        end else begin
            count_r <= atEnd ? 18'h00000 : count_r + 18'h00001;
        end
    end

    assign tick = atEnd;
endmodule : sample_strobe
`default_nettype wire

/* hw/supply_monitor_ctrl_regs.sv */
// Function
// - Mode fields encode off, continuous, sampled, reserved; boot-loaded.
// - Trip level is read-only, bits 7:3 zero, level field boot-loaded.
// - The margin field puts the warning 5, 15 or 25 percent above trip.
// - Edge field bits 2:1 pick falling below, rising above or either.
// - Bit 0 of the interrupt control register enables the warning.
// - The flag sets on the comparator transition the edge field picks.
// - The warning flag holds while the detector is disabled.
// - The status bit reads 1 while supply is below the warning level.
// - The status bit is only meaningful while the detector is enabled.
// - The request is high while enable and flag are both set.
// - The warning follows the detector mode, continuous, sampled or off.
// - Sleep field writes land only within four accesses after the key.
// - Deep sleep selects the sleep mode, otherwise the active mode.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_map.svh"
module supply_monitor_ctrl_regs
    import supply_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire supply_monitor_pkg::boot_opt_t bootOptWord,
    input wire logic bootLoad,
    input wire logic deepSleep,
    input wire logic belowWarnAsync,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic detEnable,
    output logic detSampled,
    output logic [2:0] tripLevelSel,
    output logic [1:0] warnMarginSel,
    output logic warnIrq
);
    import supply_monitor_pkg::*;

    function automatic logic modeOn(input det_mode_t m);
        modeOn = (m == MODE_CONT) || (m == MODE_SAMPLED) ||
                 (m == MODE_RSVD);
    endfunction : modeOn

    reg_req_t req;
    det_mode_t activeMode_r;
    det_mode_t sleepMode_r;
    logic sampFreq_r;
    logic [2:0] tripLevel_r;
    logic [1:0] margin_r;
    warn_edge_t edge_r;
    logic irqEn_r;
    logic flag_r;
    logic flag_nxt;
    logic state_r;
    logic prevBelow_r;
    logic [2:0] unlockCnt_r;
    logic [2:0] unlockCnt_nxt;
    logic [7:0] rdata_r;
    logic bootPend_r;
    logic belowSync;
    logic sampleTick;
    det_mode_t curMode;
    logic detOn;
    logic evalNow;
    logic fallEdge;
    logic riseEdge;
    logic trigger;
    logic clearReq;
    logic guardHit;
    logic sleepWrOk;
    logic wrMode;
    logic wrMargin;
    logic wrIrqCtl;
    logic wrFlags;
    logic wrGuard;
    logic [7:0] rdMux;

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // Comparator input brought into the clock domain
    supply_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .asyncIn(belowWarnAsync),
        .syncOut(belowSync)
    );

    // Sample pulse for sampled mode
    sample_strobe u_strobe (
        .clk(clk),
        .arst_n(arst_n),
        .slowRate(sampFreq_r),
        .tick(sampleTick)
    );

    // Effective mode: sleep field in deep sleep, active field otherwise
    assign curMode = deepSleep ? sleepMode_r : activeMode_r;
    assign detOn = modeOn(curMode);
    assign detEnable = detOn;
    assign detSampled = (curMode == MODE_SAMPLED);
    // Warning evaluated continuously or only on sample pulses
    assign evalNow = detOn && (!detSampled || sampleTick);

    // Edge detection on the synchronised comparator
    assign fallEdge = belowSync && !prevBelow_r;
    assign riseEdge = !belowSync && prevBelow_r;
    assign trigger = evalNow && (
        ((edge_r == EDGE_BELOW) && fallEdge) ||
        ((edge_r == EDGE_ABOVE) && riseEdge) ||
        ((edge_r == EDGE_CROSS) && (fallEdge || riseEdge)));

    // Address decode
    assign wrMode = req.wr && (req.addr == `SMON_OFF_MODE);
    assign wrMargin = req.wr && (req.addr == `SMON_OFF_MARGIN);
    assign wrIrqCtl = req.wr && (req.addr == `SMON_OFF_IRQCTL);
    assign wrFlags = req.wr && (req.addr == `SMON_OFF_FLAGS);
    assign wrGuard = req.wr && (req.addr == `SMON_OFF_GUARD);
    assign guardHit = wrGuard && (req.wdata == `SMON_UNLOCK_KEY);
    assign sleepWrOk = wrMode && (unlockCnt_r != 3'h0);
    assign clearReq = wrFlags && req.wdata[`SMON_FLAG_BIT];

    // Flag: set wins over clear, held while detector off
    assign flag_nxt = trigger ? 1'b1 :
                      (clearReq ? 1'b0 : flag_r);

    // Unlock window counts down on each access
    always_comb begin
        unlockCnt_nxt = unlockCnt_r;
        if (guardHit) begin
            unlockCnt_nxt = `SMON_UNLOCK_WINDOW;
        end else if (sleepWrOk) begin
            unlockCnt_nxt = 3'h0;
        end else if ((req.wr || req.rd) && unlockCnt_r != 3'h0) begin
            unlockCnt_nxt = unlockCnt_r - 3'h1;
        end
    end

    // Read mux
    always_comb begin
        rdMux = 8'h00;
        if (req.addr == `SMON_OFF_MODE) begin
            rdMux = {3'h0, sampFreq_r, activeMode_r, sleepMode_r};
        end else if (req.addr == `SMON_OFF_TRIP) begin
            rdMux = {5'h00, tripLevel_r};
        end else if (req.addr == `SMON_OFF_MARGIN) begin
            rdMux = {6'h00, margin_r};
        end else if (req.addr == `SMON_OFF_IRQCTL) begin
            rdMux = {5'h00, edge_r, irqEn_r};
        end else if (req.addr == `SMON_OFF_FLAGS) begin
            rdMux = {7'h00, flag_r};
        end else if (req.addr == `SMON_OFF_STATE) begin
            rdMux = {7'h00, state_r};
        end else if (req.addr == `SMON_OFF_GUARD) begin
            rdMux = {5'h00, unlockCnt_r};
        end
    end

    // Boot option word captured at or after reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bootPend_r <= 1'b1;
            activeMode_r <= MODE_OFF;
            sleepMode_r <= MODE_OFF;
            sampFreq_r <= 1'b0;
            tripLevel_r <= 3'h0;
        end else if (bootPend_r || bootLoad) begin
            bootPend_r <= 1'b0;
            activeMode_r <= bootOptWord.activeMode;
            sleepMode_r <= bootOptWord.sleepMode;
            sampFreq_r <= bootOptWord.sampFreq;
            tripLevel_r <= bootOptWord.tripLevel;
        end else if (sleepWrOk) begin
            sleepMode_r <= det_mode_t'(req.wdata[1:0]);
        end
    end

    // Software-written configuration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            margin_r <= 2'h0;
            edge_r <= EDGE_BELOW;
            irqEn_r <= 1'b0;
        end else if (wrMargin) begin
            margin_r <= req.wdata[1:0];
        end else if (wrIrqCtl) begin
            edge_r <= warn_edge_t'(req.wdata[2:1]);
            irqEn_r <= req.wdata[`SMON_IE_BIT];
        end
    end

    // Flag, live state, edge history, unlock and read data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_r <= 1'b0;
            state_r <= 1'b0;
            prevBelow_r <= 1'b0;
            unlockCnt_r <= 3'h0;
            rdata_r <= 8'h00;
        end else begin
            flag_r <= flag_nxt;
            if (evalNow) begin
                state_r <= belowSync;
                prevBelow_r <= belowSync;
            end
            unlockCnt_r <= unlockCnt_nxt;
            rdata_r <= req.rd ? rdMux : 8'h00;
        end
    end

    assign regRdata = rdata_r;
    assign tripLevelSel = tripLevel_r;
    assign warnMarginSel = margin_r;
    // Level request while enabled and flagged
    assign warnIrq = irqEn_r && flag_r;
endmodule : supply_monitor_ctrl_regs
`default_nettype wire

/* hw/supply_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module supply_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_r;
    logic stage2_r;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule : supply_sync
`default_nettype wire
